// *** rtl/mcs_sequencer.sv ***
// calibration and measurement sequencer for the converter front end
// Functional notes
// - reverse excitation polarity between AC phases
// - integrate, hold, 13-bit SAR via DAC
// - ten coefficients scale counts to millivolts
// - calibrate using positive and negative references
// - calibrate at power-up and watchdog reset
// - auto default, off when command in program
// - one of 22 auto steps every 8 s
// - step pause 5.4-21.4 ms only if needed; the code pauses PAUSE_CYC, 5.4 ms by default, on each of the 20 converting steps
// - auto blend new/5 plus old*4/5
// - overrun: finish pass, skip missed start
// - overrun shown on display and logged
// - command averages 10 calibrations, about 2.8 s; cmd_q clears after the 100th conversion, CMD_CYC is not waited for
// - command overwrites coefficients without blending
// - optional results to 19 locations, fault -99999
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int unsigned AUTO_CYC = AUTO_PERIOD_CYC,
  parameter int unsigned PAUSE_CYC = PAUSE_MIN_CYC,
  parameter int unsigned CMD_CYC = CMD_TIME_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic watchdog_reset,
  input wire logic prog_has_cal_cmd,
  input wire logic cal_cmd_exec,
  input wire logic cal_store_en,
  input wire logic comparator,
  input wire mcs_meas_req_t meas_req,
  input wire logic interval_tick,
  input wire logic table_done,
  output mcs_afe_t afe,
  output logic [ADC_BITS-1:0] count_q,
  output logic [COEF_W+ADC_BITS-1:0] millivolt_q,
  output logic result_valid_q,
  output logic busy_q,
  output logic prog_pause_q,
  output logic table_start_q,
  output logic overrun_disp_q,
  output logic overrun_log_q,
  output logic [15:0] overrun_count_q,
  output logic store_we_q,
  output logic [4:0] store_addr_q,
  output logic signed [31:0] store_data_q
);
  typedef enum logic [2:0] {S_IDLE, S_INTEG, S_HOLD, S_SAR, S_DONE} mcs_state_t;

  // input synchronisers
  logic [1:0] cmp_s, wd_s;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmp_s <= 2'h0;
      wd_s <= 2'h0;
    end else begin
      cmp_s <= {cmp_s[0], comparator};
      wd_s <= {wd_s[0], watchdog_reset};
    end
  end
  wire cmp = cmp_s[1];
  wire wd = wd_s[1];

  mcs_state_t st_q;
  logic [15:0] tmr_q;
  logic [3:0] bit_q;
  logic phase_q;
  logic [ADC_BITS-1:0] sar_q;
  logic [ADC_BITS:0] acc_q;
  logic ac_q, slow_q, cal_conv_q;
  logic [2:0] gain_q;
  mcs_ref_t ref_q;
  logic [COEF_W-1:0] coef_q [NUM_COEF];
  logic [COEF_W-1:0] newc_q [NUM_COEF];

  // calibration control
  logic init_pend_q, cmd_q, auto_pend_q;
  logic [31:0] auto_tmr_q, pause_tmr_q, cmd_tmr_q;
  logic [4:0] step_q;
  logic [3:0] avg_q;
  logic [3:0] cidx_q;
  logic [COEF_W+3:0] avg_acc_q;
  logic meas_pend_q;

  wire auto_en = !prog_has_cal_cmd;
  wire auto_fire = auto_en && (auto_tmr_q == AUTO_CYC - 1);
  wire step_wrap = (step_q == STEP_LAST);
  wire step_needs_conv = step_q < 5'(NUM_COEF * 2);
  wire [3:0] step_coef = step_q[4:1];
  wire conv_done = (st_q == S_DONE);
  wire [15:0] integ_len = slow_q ? INTEG_SLOW_CYC : INTEG_FAST_CYC;
  wire [ADC_BITS-1:0] trial = sar_q | (13'h1 << bit_q);
  wire cal_busy = init_pend_q || cmd_q || (pause_tmr_q != 0);
  wire start_meas = (st_q == S_IDLE) && meas_pend_q && !cal_busy;
  wire [3:0] meas_idx = {gain_q, 1'b0} + {3'h0, slow_q};
  wire [COEF_W-1:0] cal_val = COEF_W'(acc_q);
  // blend: (new + 4*old)/5
  wire [COEF_W+2:0] blend_sum = {3'h0, cal_val} + {1'b0, coef_q[step_coef], 2'h0};
  wire [COEF_W-1:0] blend = COEF_W'(blend_sum / 27'd5);
  wire [COEF_W+3:0] avg_next = avg_acc_q + {4'h0, cal_val};
  wire [COEF_W-1:0] avg_val = COEF_W'(avg_next / 28'd10);
  wire cal_fault = (cal_val == '0) || (&cal_val);

  // conversion engine
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      tmr_q <= 16'h0;
      bit_q <= 4'h0;
      phase_q <= 1'b0;
      sar_q <= '0;
      acc_q <= '0;
      ac_q <= 1'b0;
      slow_q <= 1'b0;
      gain_q <= 3'h0;
      ref_q <= MCS_REF_NONE;
      cal_conv_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          tmr_q <= 16'h0;
          phase_q <= 1'b0;
          acc_q <= '0;
          if ((init_pend_q || cmd_q || (auto_pend_q && step_needs_conv)) && !cal_conv_q) begin
            st_q <= S_INTEG;
            cal_conv_q <= 1'b1;
            ac_q <= 1'b1;
            slow_q <= init_pend_q || cmd_q ? cidx_q[0] : step_coef[0];
            gain_q <= init_pend_q || cmd_q ? cidx_q[3:1] : step_coef[3:1];
            ref_q <= MCS_REF_POS;
          end else if (start_meas) begin
            st_q <= S_INTEG;
            cal_conv_q <= 1'b0;
            ac_q <= meas_req.ac_bridge;
            slow_q <= meas_req.slow;
            gain_q <= meas_req.gain;
            ref_q <= MCS_REF_NONE;
          end
        end
        S_INTEG: begin
          tmr_q <= tmr_q + 16'h1;
          if (tmr_q == integ_len - 16'h1) begin
            st_q <= S_HOLD;
            tmr_q <= 16'h0;
          end
        end
        S_HOLD: begin
          st_q <= S_SAR;
          bit_q <= 4'(ADC_BITS - 1);
          sar_q <= '0;
        end
        S_SAR: begin
          tmr_q <= (tmr_q == SAR_SETTLE_CYC) ? 16'h0 : tmr_q + 16'h1;
          if (tmr_q == SAR_SETTLE_CYC) begin
          if (cmp) begin
            sar_q <= trial;
          end
          if (bit_q == 4'h0) begin
            if (ac_q && !phase_q) begin
              phase_q <= 1'b1;
              acc_q <= {1'b0, cmp ? trial : sar_q};
              if (cal_conv_q) begin
                ref_q <= MCS_REF_NEG;
              end
              st_q <= S_INTEG;
            end else begin
              acc_q <= acc_q + {1'b0, cmp ? trial : sar_q};
              st_q <= S_DONE;
            end
          end else begin
            bit_q <= bit_q - 4'h1;
          end
          end
        end
        S_DONE: begin
          st_q <= S_IDLE;
          ref_q <= MCS_REF_NONE;
        end
        default: st_q <= S_IDLE;
      endcase
      if (conv_done && cal_conv_q) begin
        cal_conv_q <= 1'b0;
      end
    end
  end

  // front-end drive; excitation grounded once integration ends
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      afe <= '0;
    end else begin
      afe.integrate <= (st_q == S_INTEG);
      afe.hold <= (st_q == S_HOLD) || (st_q == S_SAR);
      afe.exc_on <= (st_q == S_INTEG) && (ac_q || !cal_conv_q);
      afe.exc_neg <= ac_q && phase_q;
      afe.gain <= gain_q;
      afe.slow <= slow_q;
      afe.ref_sel <= ref_q;
      afe.dac <= (st_q == S_SAR) ? trial : sar_q;
    end
  end

  // calibration sequencing and coefficients
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      init_pend_q <= 1'b1;
      cmd_q <= 1'b0;
      auto_pend_q <= 1'b0;
      auto_tmr_q <= 32'h0;
      pause_tmr_q <= 32'h0;
      cmd_tmr_q <= 32'h0;
      step_q <= 5'h0;
      avg_q <= 4'h0;
      cidx_q <= 4'h0;
      avg_acc_q <= '0;
      meas_pend_q <= 1'b0;
      count_q <= '0;
      millivolt_q <= '0;
      result_valid_q <= 1'b0;
      store_we_q <= 1'b0;
      store_addr_q <= 5'h0;
      store_data_q <= 32'sh0;
      for (int i = 0; i < NUM_COEF; i++) begin
        coef_q[i] <= COEF_RESET;
        newc_q[i] <= COEF_RESET;
      end
    end else begin
      result_valid_q <= 1'b0;
      store_we_q <= 1'b0;
      if (meas_req.start) begin
        meas_pend_q <= 1'b1;
      end else if (start_meas) begin
        meas_pend_q <= 1'b0;
      end
      if (wd) begin
        init_pend_q <= 1'b1;
        cidx_q <= 4'h0;
      end
      if (cal_cmd_exec && !init_pend_q && !cmd_q) begin
        cmd_q <= 1'b1;
        cmd_tmr_q <= 32'h0;
        avg_q <= 4'h0;
        cidx_q <= 4'h0;
        avg_acc_q <= '0;
      end
      if (cmd_q && cmd_tmr_q < CMD_CYC) begin
        cmd_tmr_q <= cmd_tmr_q + 32'h1;
      end
      auto_tmr_q <= auto_fire || !auto_en ? 32'h0 : auto_tmr_q + 32'h1;
      if (auto_fire && !init_pend_q && !cmd_q) begin
        pause_tmr_q <= step_needs_conv ? 32'(PAUSE_CYC) : 32'h0;
        auto_pend_q <= 1'b1;
      end else if (pause_tmr_q != 0) begin
        pause_tmr_q <= pause_tmr_q - 32'h1;
      end
      if (auto_pend_q && (step_needs_conv ? (conv_done && cal_conv_q) : 1'b1)) begin
        auto_pend_q <= 1'b0;
        if (step_needs_conv && conv_done && step_q[0]) begin
          newc_q[step_coef] <= blend;
        end
        if (step_wrap) begin
          step_q <= 5'h0;
          for (int i = 0; i < NUM_COEF; i++) begin
            coef_q[i] <= newc_q[i];
          end
        end else begin
          step_q <= step_q + 5'h1;
        end
      end
      if (conv_done && cal_conv_q && (init_pend_q || cmd_q)) begin
        if (init_pend_q) begin
          coef_q[cidx_q] <= cal_val;
          cidx_q <= (cidx_q == 4'(NUM_COEF - 1)) ? 4'h0 : cidx_q + 4'h1;
          if (cidx_q == 4'(NUM_COEF - 1)) begin
            init_pend_q <= 1'b0;
          end
        end else begin
          avg_acc_q <= (avg_q == AVG_LAST) ? '0 : avg_next;
          avg_q <= (avg_q == AVG_LAST) ? 4'h0 : avg_q + 4'h1;
          if (avg_q == 4'h0 && cidx_q != 4'h0 && cal_store_en) begin
            store_we_q <= 1'b1;
            store_addr_q <= 5'(cidx_q) + 5'h09;
            store_data_q <= cal_fault ? FAULT_VALUE : 32'(cal_val);
          end
          if (avg_q == AVG_LAST) begin
            coef_q[cidx_q] <= avg_val;
            cidx_q <= cidx_q + 4'h1;
            if (cal_store_en) begin
              store_we_q <= 1'b1;
              store_addr_q <= 5'(cidx_q);
              store_data_q <= cal_fault ? FAULT_VALUE : 32'(avg_val);
            end
            if (cidx_q == 4'(NUM_COEF - 1)) begin
              cmd_q <= 1'b0;
              cidx_q <= 4'h0;
            end
          end
        end
      end
      if (conv_done && !cal_conv_q) begin
        count_q <= acc_q[ADC_BITS-1:0];
        millivolt_q <= acc_q[ADC_BITS-1:0] * coef_q[meas_idx];
        result_valid_q <= 1'b1;
      end
    end
  end

  // table scheduling and overrun report
  logic tbl_run_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tbl_run_q <= 1'b0;
      table_start_q <= 1'b0;
      overrun_disp_q <= 1'b0;
      overrun_log_q <= 1'b0;
      overrun_count_q <= 16'h0;
      busy_q <= 1'b1;
      prog_pause_q <= 1'b0;
    end else begin
      table_start_q <= 1'b0;
      overrun_log_q <= 1'b0;
      busy_q <= cal_busy || (st_q != S_IDLE);
      prog_pause_q <= cal_busy;
      if (interval_tick && !tbl_run_q && !cal_busy) begin
        tbl_run_q <= 1'b1;
        table_start_q <= 1'b1;
        overrun_disp_q <= 1'b0;
      end else if (interval_tick && (tbl_run_q || cal_busy)) begin
        overrun_disp_q <= 1'b1;
        overrun_log_q <= 1'b1;
        overrun_count_q <= overrun_count_q + 16'h1;
      end
      if (table_done && tbl_run_q) begin
        tbl_run_q <= 1'b0;
      end
    end
  end
endmodule // mcs_sequencer

// *** rtl/mcs_pkg.sv ***
// package of constants and types for the measurement calibration sequencer
package mcs_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ADC_BITS = 13;
  localparam int unsigned GAIN_RANGES = 5;
  localparam int unsigned NUM_COEF = 10;
  localparam int unsigned COEF_W = 24;
  localparam int unsigned AUTO_STEPS = 22;
  localparam int unsigned AUTO_PERIOD_S = 8;
  localparam int unsigned AUTO_PERIOD_CYC = AUTO_PERIOD_S * CLK_HZ;
  localparam int unsigned PAUSE_MIN_US = 5400;
  localparam int unsigned PAUSE_MAX_US = 21400;
  localparam int unsigned PAUSE_MIN_CYC = (PAUSE_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PAUSE_MAX_CYC = (PAUSE_MAX_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CMD_AVG = 10;
  localparam int unsigned CMD_TIME_MS = 2800;
  localparam int unsigned CMD_TIME_CYC = CMD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RESULT_LOCS = 19;
  localparam logic signed [31:0] FAULT_VALUE = -32'sd99999;
  localparam logic [COEF_W-1:0] COEF_RESET = 24'h010000;
  localparam logic [15:0] INTEG_FAST_CYC = 16'h00FA;
  localparam logic [15:0] INTEG_SLOW_CYC = 16'h0177;
  localparam logic [4:0] STEP_LAST = 5'h15;
  localparam logic [3:0] AVG_LAST = 4'h9;
  localparam logic [15:0] SAR_SETTLE_CYC = 16'h0003;

  typedef enum logic [1:0] {
    MCS_REF_NONE,
    MCS_REF_POS,
    MCS_REF_NEG
  } mcs_ref_t;

  typedef struct packed {
    logic integrate;
    logic hold;
    logic exc_on;
    logic exc_neg;
    logic [2:0] gain;
    logic slow;
    mcs_ref_t ref_sel;
    logic [ADC_BITS-1:0] dac;
  } mcs_afe_t;

  typedef struct packed {
    logic start;
    logic ac_bridge;
    logic [2:0] gain;
    logic slow;
  } mcs_meas_req_t;
endpackage : mcs_pkg

// *** sim/mcs_afe_model.sv ***
// behavioural analog front end: integrator, hold and comparator
module mcs_afe_model
  import mcs_pkg::*;
#(
  parameter logic [ADC_BITS-1:0] REF_POS_LVL = 13'h1800,
  parameter logic [ADC_BITS-1:0] REF_NEG_LVL = 13'h0800
) (
  input wire logic clock,
  input wire mcs_afe_t afe,
  input wire logic [ADC_BITS-1:0] level,
  output logic comparator
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADC_BITS-1:0] held_q = '0;
  logic junk_q = 1'b0;
  wire logic [ADC_BITS-1:0] src = (afe.ref_sel == MCS_REF_POS) ? REF_POS_LVL :
    (afe.ref_sel == MCS_REF_NEG) ? REF_NEG_LVL : level;
  always @(posedge clock) begin
    if (afe.integrate) begin
      held_q <= src;
    end
    junk_q <= ~junk_q;
  end
  // outside hold the comparator output is meaningless, so it toggles
  assign comparator = afe.hold ? (afe.dac <= held_q) : junk_q;
endmodule // mcs_afe_model

// *** sim/mcs_sequencer_sva.sv ***
// port checker for the calibration sequencer
module mcs_sequencer_sva
  import mcs_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = PAUSE_MIN_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic watchdog_reset,
  input wire logic cal_cmd_exec,
  input wire logic cal_store_en,
  input wire logic interval_tick,
  input wire logic table_done,
  input wire mcs_afe_t afe,
  input wire logic result_valid_q,
  input wire logic busy_q,
  input wire logic prog_pause_q,
  input wire logic table_start_q,
  input wire logic overrun_disp_q,
  input wire logic overrun_log_q,
  input wire logic [15:0] overrun_count_q,
  input wire logic store_we_q,
  input wire logic [4:0] store_addr_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic table_run_q;
  logic [15:0] pause_cnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      table_run_q <= 1'b0;
      pause_cnt_q <= 16'h0000;
    end else begin
      table_run_q <= table_start_q | (table_run_q & ~table_done);
      pause_cnt_q <= prog_pause_q ? pause_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  property p_valid; result_valid_q |=> !result_valid_q; endproperty
  a_valid: assert property (p_valid) else $error("result valid too long");
  property p_hold; afe.integrate |-> !afe.hold; endproperty
  a_hold: assert property (p_hold) else $error("hold during integrate");
  property p_ground; afe.hold |-> !afe.exc_on; endproperty
  a_ground: assert property (p_ground) else $error("excitation on in hold");
  property p_pause; $fell(prog_pause_q) && busy_q |-> pause_cnt_q == 16'(PAUSE_CYC); endproperty
  a_pause: assert property (p_pause) else $error("pause length wrong");
  property p_run; table_start_q |-> !table_run_q; endproperty
  a_run: assert property (p_run) else $error("table restarted while running");
  property p_ovr; interval_tick && table_run_q |-> ##[1:3] overrun_log_q; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not logged");
  property p_disp; overrun_log_q |-> ##[0:1] overrun_disp_q; endproperty
  a_disp: assert property (p_disp) else $error("overrun not displayed");
  property p_cnt; $changed(overrun_count_q) |-> overrun_count_q == $past(overrun_count_q) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("overrun count step wrong");
  property p_wd; $rose(watchdog_reset) |-> ##[1:5] busy_q; endproperty
  a_wd: assert property (p_wd) else $error("watchdog did not calibrate");
  property p_cmd; $rose(cal_cmd_exec) && !busy_q && !prog_pause_q |-> ##[1:4] busy_q; endproperty
  a_cmd: assert property (p_cmd) else $error("command did not calibrate");
  property p_store; store_we_q |-> busy_q && cal_store_en && store_addr_q < 5'h13; endproperty
  a_store: assert property (p_store) else $error("bad result store");
  c_valid: cover property (result_valid_q);
  c_ovr: cover property (overrun_log_q);
  c_store: cover property (store_we_q);
  c_neg: cover property ($rose(afe.exc_neg));
endmodule // mcs_sequencer_sva

bind mcs_sequencer mcs_sequencer_sva #(.PAUSE_CYC(PAUSE_CYC)) u_sva (
  .clock(clock), .reset_n(reset_n), .watchdog_reset(watchdog_reset),
  .cal_cmd_exec(cal_cmd_exec), .cal_store_en(cal_store_en), .interval_tick(interval_tick),
  .table_done(table_done), .afe(afe), .result_valid_q(result_valid_q), .busy_q(busy_q),
  .prog_pause_q(prog_pause_q), .table_start_q(table_start_q), .overrun_disp_q(overrun_disp_q),
  .overrun_log_q(overrun_log_q), .overrun_count_q(overrun_count_q), .store_we_q(store_we_q),
  .store_addr_q(store_addr_q));

// *** sim/mcs_sequencer_tb_top.sv ***
// self-checking bench for the calibration sequencer
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mcs_sequencer_tb_top
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, watchdog_reset, prog_has_cal_cmd, cal_cmd_exec, cal_store_en;
  logic comparator, interval_tick, table_done, result_valid_q, busy_q, prog_pause_q;
  logic table_start_q, overrun_disp_q, overrun_log_q, store_we_q;
  logic [ADC_BITS-1:0] count_q, level;
  logic [COEF_W+ADC_BITS-1:0] millivolt_q;
  logic [15:0] overrun_count_q;
  logic [4:0] store_addr_q;
  logic signed [31:0] store_data_q;
  logic [18:0] addr_seen = '0;
  logic [31:0] rng = 32'h0000A6B5;
  mcs_meas_req_t meas_req;
  mcs_afe_t afe;
  int num_errors = 0, compares = 0, e, start_n = 0, log_n = 0, store_n = 0, fault_n = 0;
  int pause_n = 0, p0, ovr_model = 0;
  bit pause_prev = 1'b0;
  int exp_q[$];

  mcs_sequencer #(.AUTO_CYC(1000), .PAUSE_CYC(50), .CMD_CYC(CMD_TIME_CYC)) u_dut (
    .clock, .reset_n, .watchdog_reset, .prog_has_cal_cmd, .cal_cmd_exec, .cal_store_en,
    .comparator, .meas_req, .interval_tick, .table_done, .afe, .count_q, .millivolt_q,
    .result_valid_q, .busy_q, .prog_pause_q, .table_start_q, .overrun_disp_q, .overrun_log_q,
    .overrun_count_q, .store_we_q, .store_addr_q, .store_data_q);
  mcs_afe_model u_afe (.clock, .afe, .level, .comparator);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  always @(negedge clock) begin
    if (result_valid_q && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e >= 0) `CHK(count_q, 13'(e))
    end
    if (store_we_q) begin
      store_n++;
      if (store_addr_q < 5'h13) addr_seen[store_addr_q] = 1'b1;
      if (store_data_q === FAULT_VALUE) fault_n++;
    end
    if (table_start_q) start_n++;
    if (overrun_log_q) log_n++;
    if (prog_pause_q && !pause_prev) pause_n++;
    pause_prev = prog_pause_q;
  end

  task automatic test_done();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy_q !== 1'b0; i++) @(negedge clock);
    if (busy_q !== 1'b0) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, busy_q, 1'b0);
      test_done();
    end
  endtask

  task automatic measure(input logic ac, input logic [2:0] g, input logic s,
                         input logic [ADC_BITS-1:0] lv);
    level = lv;
    exp_q.push_back(ac ? -1 : int'(lv));
    meas_req = {1'b1, ac, g, s};
    cyc(1);
    meas_req.start = 1'b0;
    for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(negedge clock);
    if (exp_q.size() > 0) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      test_done();
    end
  endtask

  task automatic tick(input logic done);
    table_done = done;
    cyc(1);
    table_done = 1'b0;
    interval_tick = 1'b1;
    cyc(1);
    interval_tick = 1'b0;
    cyc(4);
  endtask

  initial begin
    {reset_n, watchdog_reset, cal_cmd_exec, cal_store_en, interval_tick, table_done} = '0;
    prog_has_cal_cmd = 1'b1;
    meas_req = '0;
    level = '0;
    cyc(10);
    `CHK(busy_q, 1'b1)
    `CHK({result_valid_q, table_start_q, store_we_q, overrun_log_q, overrun_count_q}, 20'h0)
    cyc(10);
    reset_n = 1'b1;
    cyc(2);
    `CHK(busy_q, 1'b1)
    wait_idle(30000);
    measure(1'b0, 3'h0, 1'b0, 13'h0000);
    measure(1'b0, 3'h4, 1'b1, 13'h1FFF);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      measure(1'b0, 3'(rng % 5), rng[4], rng[20:8]);
    end
    measure(1'b1, 3'h2, 1'b0, 13'h0ABC);
    tick(1'b0);
    `CHK(start_n, 1)
    for (int k = 0; k < 2; k++) begin
      tick(1'b0);
      ovr_model++;
      `CHK(log_n, ovr_model)
      `CHK(overrun_count_q, 16'(ovr_model))
      `CHK(overrun_disp_q, 1'b1)
      `CHK(start_n, 1)
    end
    tick(1'b1);
    `CHK(start_n, 2)
    `CHK(overrun_disp_q, 1'b0)
    table_done = 1'b1;
    cyc(1);
    table_done = 1'b0;
    prog_has_cal_cmd = 1'b0;
    cyc(500);
    p0 = pause_n;
    cyc(22 * 1000);
    `CHK(pause_n - p0, 20)
    prog_has_cal_cmd = 1'b1;
    cyc(1500);
    p0 = pause_n;
    cyc(2000);
    `CHK(pause_n - p0, 0)
    wait_idle(5000);
    cal_store_en = 1'b1;
    p0 = store_n;
    cal_cmd_exec = 1'b1;
    cyc(1);
    cal_cmd_exec = 1'b0;
    cyc(5);
    `CHK(busy_q, 1'b1)
    wait_idle(120000);
    `CHK(store_n - p0, 19)
    `CHK(addr_seen, 19'h7FFFF)
    `CHK(fault_n, 0)
    measure(1'b0, 3'h1, 1'b0, 13'h1234);
    `CHK(millivolt_q, 37'(64'h1234 * (64'h1800 + 64'h0800)))
    watchdog_reset = 1'b1;
    cyc(1);
    watchdog_reset = 1'b0;
    cyc(6);
    `CHK(busy_q, 1'b1)
    test_done();
  end
endmodule // mcs_sequencer_tb_top
